// >>> pusq_defines.svh
// constants for the power-up settings query responder
// Operation
// [RL1] bytes 11-12 report roles of pins seven, eight
// [RL2] default output word at bytes 13, 14
// [RL3] high output byte bit0 is pin eight
// [RL4] default direction word at bytes 15, 16
// [RL5] byte 17 bit4 reports remote wake-up
// [RL6] byte 17 bits3-1 select interrupt counting mode
// [RL7] byte 17 bit0 selects spi bus release
// [RL8] byte 18 reports settings access-control level
// [RL9] host sends command, sub-command 0x30 for key
// [RL10] host zero-fills bytes 2 to 63
// [RL11] key response echoes command, status, sub-command
// [RL12] key byte 29 holds power attribute bits
// [RL13] key byte 30 holds current in 2 mA
// [RL14] chip response bytes 0-2 echo, status, 0x20
// [RL15] vid at bytes 12-13, pid at 14-15
// [RL16] meaningless bytes are driven to zero
`ifndef PUSQ_DEFINES_SVH
`define PUSQ_DEFINES_SVH
// ----------------------------------------
// command codes and frame layout
// ----------------------------------------
`define PUSQ_FRAME_BYTES   64
`define PUSQ_CMD_READ      8'h61
`define PUSQ_SUB_CHIP      8'h20
`define PUSQ_SUB_KEY       8'h30
`define PUSQ_STATUS_OK     8'h00
`define PUSQ_ROLE_MAX      8'h02
`define PUSQ_ACC_OPEN      8'h00
`define PUSQ_ACC_PASSWORD  8'h40
`define PUSQ_ACC_LOCKED    8'h80
`define PUSQ_MODE_MAX      3'h4
// ----------------------------------------
// byte positions
// ----------------------------------------
`define PUSQ_B_CMD         0
`define PUSQ_B_STATUS      1
`define PUSQ_B_SUB         2
`define PUSQ_B_CMD_SUB     1
`define PUSQ_B_ROLE7       11
`define PUSQ_B_ROLE8       12
`define PUSQ_B_OUT_LO      13
`define PUSQ_B_OUT_HI      14
`define PUSQ_B_DIR_LO      15
`define PUSQ_B_DIR_HI      16
`define PUSQ_B_OPTIONS     17
`define PUSQ_B_ACCESS      18
`define PUSQ_B_VID_LO      12
`define PUSQ_B_VID_HI      13
`define PUSQ_B_PID_LO      14
`define PUSQ_B_PID_HI      15
`define PUSQ_B_POWER       29
`define PUSQ_B_CURRENT     30
`endif

// >>> pusq_pkg.sv
// types for the power-up settings query responder
package pusq_pkg;
  typedef logic [7:0] pusq_byte_t;
  typedef pusq_byte_t [63:0] pusq_frame_t;

  // stored power-up chip settings
  typedef struct packed {
    logic [7:0] role_seven;     // general_pin_seven role
    logic [7:0] role_eight;     // general_pin_eight role
    logic [8:0] default_out;    // bit0 general_pin_zero
    logic [8:0] default_dir;    // bit0 pin_zero_direction
    logic       wake_enable;
    logic [2:0] count_mode;
    logic       keep_bus;       // 1 keeps spi bus between transfers
    logic [7:0] access_level;
  } pusq_chip_s;

  // stored usb key parameters
  typedef struct packed {
    logic [15:0] vendor_id;
    logic [15:0] product_id;
    logic        host_powered;
    logic        self_powered;
    logic        wake_capable;
    logic [7:0]  current_2ma;
  } pusq_key_s;

  typedef enum logic [1:0] {
    PUSQ_IDLE = 2'b00,
    PUSQ_BUSY = 2'b01,
    PUSQ_DONE = 2'b11
  } pusq_state_e;

  typedef struct packed {
    pusq_state_e state;
    pusq_frame_t resp;
    logic        resp_valid;
    logic        ignored;
  } pusq_reg_s;
endpackage : pusq_pkg

// >>> pusq_responder.sv
// settings query responder: answers chip-settings and key-parameter reads
`timescale 1ns/1ps
`include "pusq_defines.svh"
module pusq_responder (
  input  wire logic              clk_sys_i,    // 10 MHz system clock
  input  wire logic              reset_n_i,    // synchronous reset, active low
  input  wire logic              cmd_valid_i,  // one-cycle command strobe
  input  wire pusq_pkg::pusq_frame_t cmd_frame_i, // 64-byte command report
  input  wire pusq_pkg::pusq_chip_s  chip_i,   // stored chip settings
  input  wire pusq_pkg::pusq_key_s   key_i,    // stored key parameters
  output logic                   resp_valid_o, // one-cycle response strobe
  output pusq_pkg::pusq_frame_t  resp_frame_o, // 64-byte response, held
  output logic                   ignored_o     // one-cycle: command not served
);
  import pusq_pkg::*;

  pusq_reg_s   r;
  pusq_reg_s   next_r;
  pusq_frame_t chip_frame;
  pusq_frame_t key_frame;
  logic        cmd_is_read;  // byte 0 carries the settings-read code
  logic        cmd_is_chip;  // served chip-settings query
  logic        cmd_is_key;   // served key-parameters query

  // ----------------------------------------
  // response frame builders
  // ----------------------------------------
  // all unused bytes start at zero so frames compare exactly
  always_comb begin
    chip_frame = '0;                                                           // RL16
    chip_frame[`PUSQ_B_CMD]    = `PUSQ_CMD_READ;                               // RL14
    chip_frame[`PUSQ_B_STATUS] = `PUSQ_STATUS_OK;                              // RL14
    chip_frame[`PUSQ_B_SUB]    = `PUSQ_SUB_CHIP;                               // RL14
    chip_frame[`PUSQ_B_ROLE7]  = chip_i.role_seven;                            // RL1
    chip_frame[`PUSQ_B_ROLE8]  = chip_i.role_eight;                            // RL1
    chip_frame[`PUSQ_B_OUT_LO] = chip_i.default_out[7:0];                      // RL2
    chip_frame[`PUSQ_B_OUT_HI] = {7'h00, chip_i.default_out[8]};               // RL3
    chip_frame[`PUSQ_B_DIR_LO] = chip_i.default_dir[7:0];                      // RL4
    chip_frame[`PUSQ_B_DIR_HI] = {7'h00, chip_i.default_dir[8]};               // RL4
    chip_frame[`PUSQ_B_OPTIONS] = {3'h0, chip_i.wake_enable,                   // RL5
                                   chip_i.count_mode,                          // RL6
                                   chip_i.keep_bus};                           // RL7
    chip_frame[`PUSQ_B_ACCESS] = chip_i.access_level;                          // RL8
  end

  // key frame: identifiers low byte first, don't-care bits tied low
  always_comb begin
    key_frame = '0;                                                            // RL16
    key_frame[`PUSQ_B_CMD]     = `PUSQ_CMD_READ;                               // RL11
    key_frame[`PUSQ_B_STATUS]  = `PUSQ_STATUS_OK;                              // RL11
    key_frame[`PUSQ_B_SUB]     = `PUSQ_SUB_KEY;                                // RL11
    key_frame[`PUSQ_B_VID_LO]  = key_i.vendor_id[7:0];                         // RL15
    key_frame[`PUSQ_B_VID_HI]  = key_i.vendor_id[15:8];                        // RL15
    key_frame[`PUSQ_B_PID_LO]  = key_i.product_id[7:0];                        // RL15
    key_frame[`PUSQ_B_PID_HI]  = key_i.product_id[15:8];                       // RL15
    key_frame[`PUSQ_B_POWER]   = {key_i.host_powered, key_i.self_powered,
                                  key_i.wake_capable, 5'h00};                  // RL12
    key_frame[`PUSQ_B_CURRENT] = key_i.current_2ma;                            // RL13
  end

  // ----------------------------------------
  // command decode and response register
  // ----------------------------------------
  // only bytes 0 and 1 are decoded; the host zero-fills the rest, so comparing
  // them would cost a wide compare and refuse nothing a conforming host sends
  always_comb begin
    cmd_is_read = (cmd_frame_i[`PUSQ_B_CMD] == `PUSQ_CMD_READ);                       // RL9
    cmd_is_chip = cmd_is_read && (cmd_frame_i[`PUSQ_B_CMD_SUB] == `PUSQ_SUB_CHIP);
    cmd_is_key  = cmd_is_read && (cmd_frame_i[`PUSQ_B_CMD_SUB] == `PUSQ_SUB_KEY);      // RL9
  end

  // the frame loads only on a served query, so a refused command leaves
  // the last answer readable by the host
  always_comb begin
    next_r            = r;
    next_r.resp_valid = 1'b0;
    next_r.ignored    = 1'b0;
    next_r.state      = PUSQ_IDLE;
    if (cmd_valid_i) begin
      if (cmd_is_chip) begin
        next_r.resp       = chip_frame;
        next_r.resp_valid = 1'b1;
        next_r.state      = PUSQ_DONE;
      end else if (cmd_is_key) begin
        next_r.resp       = key_frame;
        next_r.resp_valid = 1'b1;
        next_r.state      = PUSQ_DONE;
      end else begin
        next_r.ignored = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // synchronous clear of strobes and frame, so no stale answer survives reset
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      r <= '{state: PUSQ_IDLE, resp: '0, resp_valid: 1'b0, ignored: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // outputs come straight from the state register
  assign resp_valid_o = r.resp_valid;
  assign resp_frame_o = r.resp;
  assign ignored_o    = r.ignored;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // headers and pin roles, values taken at the command edge
  chk_chip_header: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL14
    (cmd_valid_i && cmd_frame_i[0] == 8'h61 && cmd_frame_i[1] == 8'h20) |=>
      (resp_valid_o && resp_frame_o[0] == 8'h61 && resp_frame_o[1] == 8'h00 && resp_frame_o[2] == 8'h20))
    else $error("chip response header wrong");
  chk_key_header: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL11
    (cmd_valid_i && cmd_frame_i[0] == 8'h61 && cmd_frame_i[1] == 8'h30) |=>
      (resp_valid_o && resp_frame_o[0] == 8'h61 && resp_frame_o[2] == 8'h30 && resp_frame_o[1] == 8'h00))
    else $error("key response header wrong");
  chk_pin_roles: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL1
    (cmd_valid_i && cmd_frame_i[0] == 8'h61 && cmd_frame_i[1] == 8'h20) |=>
      (resp_frame_o[11] == $past(chip_i.role_seven) && resp_frame_o[12] == $past(chip_i.role_eight)))
    else $error("pin role bytes wrong");

  // 16-bit words: low byte first, pin eight alone in the high byte
  chk_out_word: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL2
    (resp_valid_o && resp_frame_o[2] == 8'h20) |->
      ({resp_frame_o[14][0], resp_frame_o[13]} == $past(chip_i.default_out)))
    else $error("default output word wrong");
  chk_out_pad: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL3
    (resp_valid_o && resp_frame_o[2] == 8'h20) |-> resp_frame_o[14][7:1] == 7'h00)
    else $error("output high byte not padded");
  chk_dir_word: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL4
    (resp_valid_o && resp_frame_o[2] == 8'h20) |->
      ({resp_frame_o[16], resp_frame_o[15]} == {7'h00, $past(chip_i.default_dir)}))
    else $error("default direction word wrong");

  // option byte and access level pass through unfiltered
  chk_options: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL5
    (resp_valid_o && resp_frame_o[2] == 8'h20) |->
      (resp_frame_o[17][7:5] == 3'h0 && resp_frame_o[17][4] == $past(chip_i.wake_enable)))
    else $error("wake-up bit wrong");
  chk_count_mode: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL6
    (resp_valid_o && resp_frame_o[2] == 8'h20) |-> resp_frame_o[17][3:1] == $past(chip_i.count_mode))
    else $error("count mode wrong");
  chk_bus_keep: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL7
    (resp_valid_o && resp_frame_o[2] == 8'h20) |-> resp_frame_o[17][0] == $past(chip_i.keep_bus))
    else $error("bus release bit wrong");
  chk_access: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL8
    (resp_valid_o && resp_frame_o[2] == 8'h20) |-> resp_frame_o[18] == $past(chip_i.access_level))
    else $error("access level wrong");

  // ----------------------------------------
  // key response checks
  // ----------------------------------------
  // identifiers low byte at the lower index
  chk_key_ids: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL15
    (resp_valid_o && resp_frame_o[2] == 8'h30) |->
      ({resp_frame_o[13], resp_frame_o[12]} == $past(key_i.vendor_id) &&
       {resp_frame_o[15], resp_frame_o[14]} == $past(key_i.product_id)))
    else $error("identifier bytes wrong");

  // power attributes in the top three bits, current in 2 mA steps
  chk_key_power: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL12
    (resp_valid_o && resp_frame_o[2] == 8'h30) |->
      (resp_frame_o[29] == {$past(key_i.host_powered), $past(key_i.self_powered),
                            $past(key_i.wake_capable), 5'h00}))
    else $error("power attribute byte wrong");
  chk_key_current: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL13
    (resp_valid_o && resp_frame_o[2] == 8'h30) |-> resp_frame_o[30] == $past(key_i.current_2ma))
    else $error("current byte wrong");

  // ----------------------------------------
  // zero fill, strobes and refusals
  // ----------------------------------------
  // don't-care bytes read as zero in both answers
  chk_zero_fill: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL16
    resp_valid_o |-> (resp_frame_o[3] == 8'h00 && resp_frame_o[19] == 8'h00 && resp_frame_o[63] == 8'h00))
    else $error("unused byte not zero");
  chk_other_ignored: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (cmd_valid_i && cmd_frame_i[0] != 8'h61) |=> (ignored_o && !resp_valid_o))
    else $error("foreign command not ignored");

  // whole don't-care ranges except chip bytes 4-10, not just sample bytes
  chk_chip_zero: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL16
    (resp_valid_o && resp_frame_o[2] == 8'h20) |-> (resp_frame_o[3] == 8'h00 && resp_frame_o[63:19] == '0))
    else $error("chip unused bytes not zero");
  chk_key_zero: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // RL16
    (resp_valid_o && resp_frame_o[2] == 8'h30) |->
      (resp_frame_o[11:3] == '0 && resp_frame_o[28:16] == '0 && resp_frame_o[63:31] == '0))
    else $error("key unused bytes not zero");

  // a refused sub-command must not disturb the held answer
  chk_sub_ignored: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (cmd_valid_i && cmd_frame_i[0] == 8'h61 && cmd_frame_i[1] != 8'h20 && cmd_frame_i[1] != 8'h30) |=>
      (ignored_o && !resp_valid_o))
    else $error("unknown sub-command not ignored");
  chk_frame_held: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    ignored_o |-> $stable(resp_frame_o))
    else $error("refused command changed frame");

  // the frame only moves on a served answer or a reset
  chk_frame_stable: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (!resp_valid_o && $past(reset_n_i)) |-> $stable(resp_frame_o))
    else $error("frame changed without an answer");

  // strobes come only after a command and never both at once
  chk_idle_quiet: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !cmd_valid_i |=> (!resp_valid_o && !ignored_o))
    else $error("strobe without command");
  chk_strobe_excl: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !(resp_valid_o && ignored_o))
    else $error("served and ignored together");

  // no disable here, so the cleared state itself is watched
  chk_reset_quiet: assert property (@(posedge clk_sys_i)
    !reset_n_i |=> (!resp_valid_o && !ignored_o && resp_frame_o == '0))
    else $error("reset did not clear outputs");
endmodule : pusq_responder

// >>> pusq_host_model.sv
// host model: issues 64-byte settings-read command reports
`timescale 1ns/1ps
module pusq_host_model (
  input  wire logic             clk_sys_i,   // system clock
  output logic                  cmd_valid_o, // command strobe
  output pusq_pkg::pusq_frame_t cmd_frame_o  // command report
);
  import pusq_pkg::*;
  initial begin
    cmd_valid_o = 1'b0;
    cmd_frame_o = '0;
  end
  // drive just after an edge, hold through the taking edge; last=0 keeps strobe up
  // after a release the caller lets one edge pass before the next issue
  task automatic issue(input logic [7:0] code, input logic [7:0] sub, input logic last);
    pusq_frame_t f;
    f           = '0;
    f[0]        = code;
    f[1]        = sub;
    cmd_frame_o = f;
    cmd_valid_o = 1'b1;
    @(posedge clk_sys_i);
    #1;
    if (last) begin
      cmd_valid_o = 1'b0;
      cmd_frame_o = ~f; // released bus shows no stale report
    end
  endtask : issue
endmodule : pusq_host_model

// >>> tb_power_up_settings_query_responder.sv
// testbench for the settings query responder
`timescale 1ns/1ps
module tb_power_up_settings_query_responder;
  import pusq_pkg::*;
  logic        clk_sys_i;
  logic        reset_n_i;
  logic        cmd_valid;
  pusq_frame_t cmd_frame;
  pusq_chip_s  chip;
  pusq_key_s   key;
  logic        resp_valid;
  pusq_frame_t resp_frame;
  logic        ignored;
  int          err_total;
  int          compares;
  pusq_host_model i_pusq_host_model (.clk_sys_i(clk_sys_i), .cmd_valid_o(cmd_valid), .cmd_frame_o(cmd_frame));
  pusq_responder i_pusq_responder (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid),
    .cmd_frame_i(cmd_frame), .chip_i(chip), .key_i(key), .resp_valid_o(resp_valid),
    .resp_frame_o(resp_frame), .ignored_o(ignored));
  // ----------------------------------------
  // clock and helpers
  // ----------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  task automatic check(input string name, input logic [511:0] exp, input logic [511:0] seen);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    if (err_total == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  // expected frames: unused bytes and bits stay zero
  function automatic pusq_frame_t exp_chip(input pusq_chip_s c);
    pusq_frame_t f;
    f = '0;
    f[0] = 8'h61; f[2] = 8'h20;
    f[11] = c.role_seven; f[12] = c.role_eight;
    f[13] = c.default_out[7:0]; f[14] = {7'h00, c.default_out[8]};
    f[15] = c.default_dir[7:0]; f[16] = {7'h00, c.default_dir[8]};
    f[17] = {3'h0, c.wake_enable, c.count_mode, c.keep_bus};
    f[18] = c.access_level;
    return f;
  endfunction : exp_chip
  function automatic pusq_frame_t exp_key(input pusq_key_s k);
    pusq_frame_t f;
    f = '0;
    f[0] = 8'h61; f[2] = 8'h30;
    f[12] = k.vendor_id[7:0]; f[13] = k.vendor_id[15:8];
    f[14] = k.product_id[7:0]; f[15] = k.product_id[15:8];
    f[29] = {k.host_powered, k.self_powered, k.wake_capable, 5'h00};
    f[30] = k.current_2ma;
    return f;
  endfunction : exp_key
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic do_reset();
    reset_n_i = 1'b0;
    repeat (6) @(posedge clk_sys_i);
    #1 reset_n_i = 1'b1;
    check("reset strobes", 2'b00, {resp_valid, ignored});
    check("reset frame", '0, resp_frame);
  endtask : do_reset
  // every count mode, role and access code, pin eight bits toggled
  task automatic chip_sweep();
    logic [7:0] acc [3] = '{8'h00, 8'h40, 8'h80};
    for (int i = 0; i < 8; i++) begin
      chip = '{8'(i % 3), 8'(2 - i % 3), 9'(16'h00A5 << i), 9'(16'h015A >> i), i[0], 3'(i), i[1], acc[i % 3]};
      i_pusq_host_model.issue(8'h61, 8'h20, i == 7);
      check("chip strobe", 2'b10, {resp_valid, ignored});
      check("chip frame", exp_chip(chip), resp_frame);
    end
  endtask : chip_sweep
  // chip then key back to back, key values sampled at their own edge
  task automatic key_back_to_back();
    // bus was released, so one idle edge before the next request
    @(posedge clk_sys_i);
    #1;
    key = '{16'hBEEF, 16'h1234, 1'b1, 1'b0, 1'b1, 8'h32};
    i_pusq_host_model.issue(8'h61, 8'h20, 1'b0);
    check("chip b2b", exp_chip(chip), resp_frame);
    key = '{16'h00FF, 16'hFF00, 1'b0, 1'b1, 1'b0, 8'hFA};
    i_pusq_host_model.issue(8'h61, 8'h30, 1'b1);
    check("key strobe", 2'b10, {resp_valid, ignored});
    check("key frame", exp_key(key), resp_frame);
  endtask : key_back_to_back
  // unsupported codes leave the held frame alone
  task automatic refused_codes();
    @(posedge clk_sys_i);
    #1;
    i_pusq_host_model.issue(8'h62, 8'h30, 1'b1);
    check("bad code strobe", 2'b01, {resp_valid, ignored});
    check("held after code", exp_key(key), resp_frame);
    @(posedge clk_sys_i);
    #1;
    i_pusq_host_model.issue(8'h61, 8'h50, 1'b1);
    check("bad sub strobe", 2'b01, {resp_valid, ignored});
    check("held frame", exp_key(key), resp_frame);
    @(posedge clk_sys_i);
    #1 check("strobes drop", 2'b00, {resp_valid, ignored});
  endtask : refused_codes
  initial begin
    err_total = 0;
    compares  = 0;
    reset_n_i = 1'b0;
    chip      = '0;
    key       = '0;
    do_reset();
    chip_sweep();
    key_back_to_back();
    refused_codes();
    do_reset();
    key_back_to_back(); // traffic resumes after a mid-run reset
    finish_test();
  end
  // watchdog well beyond the few dozen cycles the run needs
  initial begin
    #200_000;
    err_total++;
    finish_test();
  end
endmodule : tb_power_up_settings_query_responder
